//--- core/wan_defs.vh
// constants for the warning annunciator queue
`ifndef WAN_DEFS_VH
`define WAN_DEFS_VH

// ==========================================
// list and vector sizes
`define WAN_NUM_WARN 128
`define WAN_IDX_W 7
`define WAN_LIST_LEN 8
`define WAN_EMPTY 7'h00
// ==========================================
// summary bit position in the system warning word
`define WAN_SUMMARY_POS 0
`define WAN_WORD_W 16

// ==========================================
// sequencer states
`define WAN_ST_IDLE 2'h0
`define WAN_ST_PRUNE 2'h1
`define WAN_ST_SCAN 2'h2
`define WAN_ST_DONE 2'h3

`endif

//--- core/wan_list_mem.v
// eight-entry warning number list storage with registered read
`timescale 1ns/1ps
`include "wan_defs.vh"

module wan_list_mem #(
	parameter DEPTH = `WAN_LIST_LEN,
	parameter AW = 3,
	parameter DW = `WAN_IDX_W
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// write port
	input wire writeEn,
	input wire [AW-1:0] writeAddr,
	input wire [DW-1:0] writeData,
	// clear all
	input wire clearAll,
	// registered read port
	input wire [AW-1:0] readAddr,
	output reg [DW-1:0] readData,
	// flat view of all entries
	output wire [DEPTH*DW-1:0] allEntries
);

	reg [DW-1:0] mem [0:DEPTH-1];
	integer i;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : gFlat
			assign allEntries[g*DW +: DW] = mem[g];
		end
	endgenerate

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {DW{1'b0}};
			end
			readData <= {DW{1'b0}};
		end else begin
			if (clearAll) begin
				for (i = 0; i < DEPTH; i = i + 1) begin
					mem[i] <= {DW{1'b0}};
				end
			end else if (writeEn) begin
				mem[writeAddr] <= writeData;
			end
			readData <= mem[readAddr];
		end
	end

endmodule // wan_list_mem

//--- core/wan_warning_queue.v
// warning annunciator: summary bit and ordered active warning list
`timescale 1ns/1ps
`include "wan_defs.vh"

module wan_warning_queue #(
	parameter NUM_WARN = `WAN_NUM_WARN,
	parameter IDX_W = `WAN_IDX_W,
	parameter LIST_LEN = `WAN_LIST_LEN
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// scan engine
	input wire scanEnd,
	output wire evalBusy,
	output reg evalDone,
	// warning flags from the user program
	input wire [NUM_WARN-1:0] extWarningBits,
	// list and summary
	output wire [LIST_LEN*IDX_W-1:0] activeWarningList,
	output reg warningSummaryBit,
	output wire [`WAN_WORD_W-1:0] systemWarningWord,
	// list read port
	input wire [2:0] listReadAddr,
	output wire [IDX_W-1:0] listReadData
);

	// ==========================================
	// state
	reg [1:0] state;
	reg [1:0] next_state;
	reg [NUM_WARN-1:0] snap;
	reg [IDX_W-1:0] cursor;
	reg [3:0] count;
	reg [3:0] pruneIdx;
	reg [IDX_W-1:0] list [0:LIST_LEN-1];
	integer k;

	// membership test against the current list
	function inList;
		input [IDX_W-1:0] num;
		integer j;
		begin
			inList = 1'b0;
			for (j = 0; j < LIST_LEN; j = j + 1) begin
				if (j < count && list[j] == num) begin
					inList = 1'b1;
				end
			end
		end
	endfunction

	wire anyActive = |snap;
	wire [IDX_W-1:0] pruneEntry = list[pruneIdx[2:0]];
	wire pruneKeep = snap[pruneEntry];
	// last vector index, cut to entry width on purpose
	localparam [31:0] LAST_FULL = NUM_WARN - 1;
	wire [IDX_W-1:0] lastIdx = LAST_FULL[IDX_W-1:0];

	// ==========================================
	// next state
	always @* begin
		next_state = state;
		case (state)
			`WAN_ST_IDLE: begin
				if (scanEnd) begin
					next_state = `WAN_ST_PRUNE;
				end
			end
			`WAN_ST_PRUNE: begin
				if (!anyActive) begin
					next_state = `WAN_ST_DONE;
				end else if (pruneIdx >= count) begin
					next_state = `WAN_ST_SCAN;
				end
			end
			`WAN_ST_SCAN: begin
				if (cursor == lastIdx || count == LIST_LEN) begin
					next_state = `WAN_ST_DONE;
				end
			end
			`WAN_ST_DONE: next_state = `WAN_ST_IDLE;
			default: next_state = `WAN_ST_IDLE;
		endcase
	end

	// ==========================================
	// sequencer datapath
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= `WAN_ST_IDLE;
			snap <= {NUM_WARN{1'b0}};
			cursor <= {IDX_W{1'b0}};
			count <= 4'h0;
			pruneIdx <= 4'h0;
			warningSummaryBit <= 1'b0;
			evalDone <= 1'b0;
			for (k = 0; k < LIST_LEN; k = k + 1) begin
				list[k] <= `WAN_EMPTY;
			end
		end else begin
			state <= next_state;
			evalDone <= 1'b0;
			case (state)
				`WAN_ST_IDLE: begin
					if (scanEnd) begin
						snap <= extWarningBits;
						pruneIdx <= 4'h0;
						cursor <= {IDX_W{1'b0}};
					end
				end
				`WAN_ST_PRUNE: begin
					if (!anyActive) begin
						for (k = 0; k < LIST_LEN; k = k + 1) begin
							list[k] <= `WAN_EMPTY;
						end
						count <= 4'h0;
					end else if (pruneIdx < count) begin
						if (pruneKeep) begin
							pruneIdx <= pruneIdx + 4'h1;
						end else begin
							// drop entry, slide later ones down
							for (k = 0; k < LIST_LEN - 1; k = k + 1) begin
								if (k >= pruneIdx) begin
									list[k] <= list[k+1];
								end
							end
							list[LIST_LEN-1] <= `WAN_EMPTY;
							count <= count - 4'h1;
						end
					end
				end
				`WAN_ST_SCAN: begin
					// append new warnings after older ones
					if (count < LIST_LEN && snap[cursor] && cursor != `WAN_EMPTY
							&& !inList(cursor)) begin
						list[count[2:0]] <= cursor;
						count <= count + 4'h1;
					end
					cursor <= cursor + {{(IDX_W-1){1'b0}}, 1'b1};
				end
				`WAN_ST_DONE: begin
					warningSummaryBit <= anyActive;
					evalDone <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// ==========================================
	// outputs; no halt or output-off path exists
	assign evalBusy = (state != `WAN_ST_IDLE);
	assign systemWarningWord = {{(`WAN_WORD_W-1){1'b0}}, warningSummaryBit};

	genvar g;
	generate
		for (g = 0; g < LIST_LEN; g = g + 1) begin : gOut
			assign activeWarningList[g*IDX_W +: IDX_W] = list[g];
		end
	endgenerate

	// mirror of list entry 0 for registered readback
	wan_list_mem #(
		.DEPTH(LIST_LEN),
		.AW(3),
		.DW(IDX_W)
	) uMem (
		.clk(clk),
		.reset_n(reset_n),
		.writeEn(evalDone),
		.writeAddr(3'h0),
		.writeData(list[0]),
		.clearAll(1'b0),
		.readAddr(listReadAddr),
		.readData(listReadData),
		.allEntries()
	);

endmodule // wan_warning_queue

//--- verif/wan_user_prog.sv
// user program model driving the warning vector
`timescale 1ns/1ps
module wan_user_prog (
	// clock
	input wire clk,
	// warning vector
	output reg [127:0] extWarningBits
);
	initial extWarningBits = 128'h0;
	// set or clear flags just after an edge
	task put(input [127:0] v);
		begin
			@(posedge clk);
			extWarningBits <= v;
		end
	endtask
endmodule // wan_user_prog

//--- verif/wan_warning_queue_checker.sv
// assertions on the warning queue ports
`timescale 1ns/1ps
module wan_warning_queue_checker (
	input wire clk,
	input wire reset_n,
	input wire scanEnd,
	input wire evalBusy,
	input wire evalDone,
	input wire [55:0] activeWarningList,
	input wire warningSummaryBit,
	input wire [15:0] systemWarningWord
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	reg gap;
	integer i;
	// ====
	// hole detector
	always @* begin
		gap = 1'b0;
		for (i = 0; i < 7; i = i + 1)
			if (activeWarningList[i*7+:7] == 7'h00 && activeWarningList[i*7+7+:7] != 7'h00)
				gap = 1'b1;
	end
	chk_take_busy: assert property (scanEnd && !evalBusy |=> evalBusy) else $error("no eval");
	chk_eval_bound: assert property (scanEnd && !evalBusy |-> ##[1:200] evalDone) else $error("hang");
	chk_done_pulse: assert property (evalDone |=> !evalDone) else $error("long done");
	chk_sum_word: assert property (systemWarningWord == {15'h0, warningSummaryBit})
		else $error("word");
	chk_sum_stable: assert property (!evalDone |-> $stable(warningSummaryBit)) else $error("sum");
	chk_list_stable: assert property (!evalBusy ##1 !evalBusy |-> $stable(activeWarningList))
		else $error("list moved");
	chk_list_packed: assert property (!evalBusy |-> !gap) else $error("hole in list");
	chk_empty_clear: assert property (evalDone && !warningSummaryBit |-> activeWarningList == 0)
		else $error("list not cleared");
endmodule // wan_warning_queue_checker

//--- verif/wan_warning_queue_tb.sv
// testbench for the warning annunciator queue
`timescale 1ns/1ps
module wan_warning_queue_tb;
	reg clk, reset_n, scanEnd;
	wire evalBusy, evalDone, warningSummaryBit;
	wire [127:0] extWarningBits;
	wire [55:0] activeWarningList;
	wire [15:0] systemWarningWord;
	wire [6:0] listReadData;
	integer badCount = 0, checksDone = 0, cyc = 0;
	wan_user_prog wan_user_prog_i (.clk(clk), .extWarningBits(extWarningBits));
	wan_warning_queue wan_warning_queue_i (.clk(clk), .reset_n(reset_n), .scanEnd(scanEnd),
		.evalBusy(evalBusy), .evalDone(evalDone), .extWarningBits(extWarningBits),
		.activeWarningList(activeWarningList), .warningSummaryBit(warningSummaryBit),
		.systemWarningWord(systemWarningWord), .listReadAddr(3'h0), .listReadData(listReadData));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task chk(input [55:0] seen, input [55:0] exp);
		begin
			checksDone = checksDone + 1;
			if (seen !== exp) begin
				badCount = badCount + 1;
				$display("Error %0t: got %h want %h", $time, seen, exp);
			end
		end
	endtask
	function [55:0] pk(input integer a, b, c, d, e, f, g, h);
		pk = {h[6:0], g[6:0], f[6:0], e[6:0], d[6:0], c[6:0], b[6:0], a[6:0]};
	endfunction
	// ====
	// one scan end with a new vector
	task scan(input [127:0] v);
		integer k;
		begin
			wan_user_prog_i.put(v);
			scanEnd <= 1'b1;
			@(posedge clk);
			scanEnd <= 1'b0;
			k = 0;
			while (evalDone !== 1'b1 && k < 300) begin
				@(posedge clk);
				#1;
				k = k + 1;
			end
			chk({55'h0, evalDone}, 56'h1);
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", checksDone, badCount);
			if (badCount == 0 && checksDone > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			badCount = badCount + 1;
			wrap_up;
		end
	end
	// ====
	// test sequence
	initial begin
		reset_n = 1'b0;
		scanEnd = 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		scan(128'h400);
		chk(activeWarningList, pk(10, 0, 0, 0, 0, 0, 0, 0));
		chk({55'h0, warningSummaryBit}, 56'h1);
		repeat (2) @(posedge clk);
		#1 chk({49'h0, listReadData}, 56'ha);
		$display("test 1 done");
		scan(128'h0000_0000_0000_0800_1004_0100_0000_840E);
		chk(activeWarningList, pk(10, 1, 2, 3, 15, 40, 50, 60));
		$display("test 2 done");
		scan(128'h0000_0000_0000_0800_1004_0100_0000_800E);
		chk(activeWarningList, pk(1, 2, 3, 15, 40, 50, 60, 75));
		repeat (2) @(posedge clk);
		#1 chk({49'h0, listReadData}, 56'h1);
		$display("test 3 done");
		scan(128'h1);
		chk(activeWarningList, 56'h0);
		chk({55'h0, warningSummaryBit}, 56'h1);
		$display("test 4 done");
		scan(128'h0);
		chk(activeWarningList, 56'h0);
		chk({40'h00_0000_0000, systemWarningWord}, 56'h0);
		$display("test 5 done");
		wrap_up;
	end
endmodule // wan_warning_queue_tb
bind wan_warning_queue wan_warning_queue_checker wan_warning_queue_checker_i (.clk(clk),
	.reset_n(reset_n), .scanEnd(scanEnd), .evalBusy(evalBusy), .evalDone(evalDone),
	.activeWarningList(activeWarningList), .warningSummaryBit(warningSummaryBit),
	.systemWarningWord(systemWarningWord));
